// >>> pkg/eepw_cyc_if.sv
// one pin-level bus cycle request between sequencer and pin driver
`timescale 1ns/1ps
`default_nettype none
interface eepw_cyc_if;
  import eepw_pkg::*;
  logic req;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic ack;
  modport ctl (output req, output wr, output addr, output wdata,
               input rdata, input ack);
  modport cyc (input req, input wr, input addr, input wdata,
               output rdata, output ack);
endinterface
`default_nettype wire

// >>> pkg/eepw_pkg.sv
// constants and types for the page-write eeprom host controller
// What this block does
// RULE1 - device drives data only on read strobes
// RULE2 - device latches address late, data early
// RULE3 - busy device returns inverted bit seven
// RULE4 - true data read means next cycle allowed
// RULE5 - host may poll anytime during programming
// RULE6 - page holds one to sixty-four bytes
// RULE7 - each write restarts the byte-load window
// RULE8 - host writes next byte before window expires
// RULE9 - host steps address bits zero to five
// RULE10 - window expiry starts internal page programming
// RULE11 - programming time independent of byte count
// RULE12 - programming finishes within ten milliseconds
// RULE13 - protection off as delivered
// RULE14 - three code writes switch protection on
// RULE15 - protected writes need three-byte unlock prefix
// RULE16 - unlocked-less protected write starts timers only
// RULE17 - six-write sequence clears protection
// RULE18 - protection survives power cycling
// RULE19 - protection kept per 32-Kbyte block
// RULE20 - protection change applies at write end
// RULE21 - writes wait power-on delay after supply
// RULE22 - writes ignored below supply threshold
// RULE23 - control pins inhibit write start
// RULE24 - short strobe pulses are rejected
// RULE25 - upper address bits fixed within page
package eepw_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int PAGE_BYTES = 64;
  localparam int PAGE_LSB = 6;
  localparam int CLK_PS = 4000;

  // pin timing, nanoseconds; least times round up
  localparam int T_AS_NS = 30;
  localparam int T_WP_NS = 150;
  localparam int T_WPH_NS = 50;
  localparam int T_OE_NS = 100;
  localparam int T_DF_NS = 70;
  localparam int AS_CYC = (T_AS_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int WP_CYC = (T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int WPH_CYC = (T_WPH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int OE_CYC = (T_OE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int DF_CYC = (T_DF_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int SYNC_CYC = 2;

  // long times
  localparam int BYTE_LOAD_WINDOW_US = 150;
  localparam int T_WC_MS = 10;
  localparam int T_PWR_MS = 5;
  localparam int BLW_CYC = BYTE_LOAD_WINDOW_US * 1000000 / CLK_PS;
  localparam int WC_CYC = (T_WC_MS * 1000000 + CLK_PS / 1000 - 1)
                          / (CLK_PS / 1000);
  localparam int PWR_CYC = (T_PWR_MS * 1000000 + CLK_PS / 1000 - 1)
                           / (CLK_PS / 1000);
  localparam int LOAD_MARGIN_CYC = 128;
  localparam int CNT_W = 22;

  // command sequences
  localparam logic [ADDR_W-1:0] SEQ_ADDR_A = 15'h5555;
  localparam logic [ADDR_W-1:0] SEQ_ADDR_B = 15'h2aaa;
  localparam logic [7:0] CODE_AA = 8'haa;
  localparam logic [7:0] CODE_55 = 8'h55;
  localparam logic [7:0] CODE_80 = 8'h80;
  localparam logic [7:0] CODE_20 = 8'h20;
  localparam logic [7:0] CODE_PROT_DEF = 8'ha0;

  typedef enum logic [1:0] {
    MD_PLAIN,
    MD_PROTECT,
    MD_UNPROTECT
  } eepw_mode_t;
endpackage

// >>> sim/eepw_host_sva.sv
// pin and handshake assertions for the page-write host
`timescale 1ns/1ps
`default_nettype none
module eepw_host_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic done,
  input wire logic err,
  input wire logic [eepw_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [eepw_pkg::DATA_W-1:0] mem_dq_out,
  input wire logic mem_dq_oe_n,
  input wire logic mem_cs_n,
  input wire logic mem_we_n,
  input wire logic mem_oe_n
);
  import eepw_pkg::*;
  logic [7:0] lo_q;
  logic [7:0] hi_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // strobe low and high times in cycles; high count saturates when idle
  always_ff @(posedge ref_clk) begin
    lo_q <= (rst || mem_we_n) ? 8'h00 : lo_q + 8'h01;
    if (rst || !mem_we_n) hi_q <= 8'h00;
    else if (hi_q != 8'hff) hi_q <= hi_q + 8'h01;
  end
  wr_rd_excl_a:
  assert property (mem_we_n || mem_oe_n) else $error("strobes clash");
  wr_select_a:
  assert property ($fell(mem_we_n) |-> !mem_cs_n && mem_oe_n && !mem_dq_oe_n)
    else $error("write strobe without select");
  rd_release_a:
  assert property (!mem_oe_n |-> mem_dq_oe_n && mem_we_n)
    else $error("host drives bus during read");
  wr_hold_a:
  assert property (!mem_we_n && !$past(mem_we_n) |->
    $stable(mem_addr) && $stable(mem_dq_out)) else $error("write not held");
  wp_width_a:
  assert property ($rose(mem_we_n) |-> lo_q >= 8'(WP_CYC))
    else $error("write pulse too short");
  wph_a:
  assert property ($fell(mem_we_n) |-> hi_q >= 8'(WPH_CYC))
    else $error("write high time too short");
  done_pulse_a:
  assert property (done |=> !done) else $error("done longer than a cycle");
  take_drop_a:
  assert property (req_valid && req_ready |=> !req_ready)
    else $error("ready held after take");
  err_done_a:
  assert property ($rose(err) |-> done) else $error("err without done");
endmodule // eepw_host_sva
bind eepw_host eepw_host_sva i_sva (.ref_clk(ref_clk), .rst(rst),
  .req_valid(req_valid), .req_ready(req_ready), .done(done), .err(err),
  .mem_addr(mem_addr), .mem_dq_out(mem_dq_out), .mem_dq_oe_n(mem_dq_oe_n),
  .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n));
`default_nettype wire

// >>> sim/eepw_mem_model.sv
// behavioural page-write eeprom as seen from its pins
`timescale 1ns/1ps
`default_nettype none
module eepw_mem_model #(
  parameter int WIN = 400,
  parameter int PROG = 600,
  parameter int PWR = 64,
  parameter int FILT = 2,
  parameter logic [7:0] PCODE = 8'ha0
) (
  input wire logic clk,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [14:0] addr,
  input wire logic [31:0] din,
  output logic [31:0] dout
);
  logic [31:0] mem [0:32767];
  logic [14:0] pa [0:63];
  logic [31:0] pd [0:63];
  logic [14:0] al, last;
  logic [31:0] ld, hold;
  logic we_q = 1, cs_q = 1;
  int n = 0, tmr = 0, bt = 0, k, pwr = 0, wl = 0;
  bit busy = 0;
  bit [3:0] prot = 4'h0;
  wire rd = !cs_n && !oe_n && we_n;
  function automatic bit hit(int i, int j, logic [14:0] a, logic [7:0] c);
    return n > i && pa[i] == a && pd[i][8*j+:8] == c;
  endfunction
  // pins sampled mid-cycle: the host moves them on the rising edge
  always @(negedge clk) begin
    // supply taken as past its threshold from time zero
    if (pwr < PWR) pwr++;
    if (we_q && !we_n && !cs_n && oe_n) al = addr;
    // short, inhibited or too-early pulses never load a byte
    if (!we_q && we_n && !cs_q && n < 64 &&
        wl >= FILT && pwr == PWR) begin
      pa[n] = al;
      pd[n] = din;
      ld = din;
      last = al;
      n++;
      tmr = 0;
    end
    if (n > 0 && ++tmr == WIN) begin
      // one 32-Kbyte chip per byte lane, each with its own protection
      for (int j = 0; j < 4; j++) begin
        k = prot[j] ? 64 : 0;
        if (hit(0, j, 15'h5555, 8'haa) && hit(1, j, 15'h2aaa, 8'h55)) begin
          if (hit(2, j, 15'h5555, 8'h80) && hit(3, j, 15'h5555, 8'haa) &&
              hit(4, j, 15'h2aaa, 8'h55) && hit(5, j, 15'h5555, 8'h20)) begin
            prot[j] = 0;
            k = 6;
          end else if (hit(2, j, 15'h5555, PCODE)) begin
            prot[j] = 1;
            k = 3;
          end
        end
        for (int i = k; i < n; i++)
          mem[pa[i]][8*j+:8] = pd[i][8*j+:8];
      end
      busy = 1;
      bt = 0;
      n = 0;
    end
    if (busy && ++bt == PROG) busy = 0;
    if (rd) hold = dout;
    wl = (!we_n && !cs_n && oe_n) ? wl + 1 : 0;
    we_q = we_n;
    cs_q = cs_n;
  end
  // released bus shows the inverse of the last value, not a kind constant
  assign dout = !rd ? ~hold : (busy && addr == last) ?
                ld ^ 32'h80808080 : mem[addr];
endmodule // eepw_mem_model
`default_nettype wire

// >>> sim/test_eeprom_page_write_protect.sv
// self-checking bench: page-write host against the eeprom model
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_page_write_protect;
  import eepw_pkg::*;
  logic ref_clk = 0, rst = 1, req_valid, req_nodata, req_last;
  eepw_mode_t req_mode;
  logic [ADDR_W-1:0] req_addr, mem_addr;
  logic [DATA_W-1:0] req_data, mem_dq_out, mem_dq_in, dout;
  logic req_ready, done, err, mem_dq_oe_n, mem_cs_n, mem_we_n, mem_oe_n;
  logic [31:0] d [0:63];
  logic exp_q [$];
  int n_errors = 0, n_tests = 0;
  assign mem_dq_in = mem_dq_oe_n ? dout : mem_dq_out;
  eepw_host #(.BLW_CYCLES(400), .WC_CYCLES(2000), .PWR_CYCLES(20)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_mode(req_mode), .req_nodata(req_nodata),
    .req_last(req_last), .req_addr(req_addr), .req_data(req_data),
    .done(done), .err(err), .mem_addr(mem_addr), .mem_dq_out(mem_dq_out),
    .mem_dq_oe_n(mem_dq_oe_n), .mem_dq_in(mem_dq_in), .mem_cs_n(mem_cs_n),
    .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n));
  eepw_mem_model i_mem (.clk(ref_clk), .cs_n(mem_cs_n), .we_n(mem_we_n),
    .oe_n(mem_oe_n), .addr(mem_addr), .din(mem_dq_out), .dout(dout));
  initial forever #2 ref_clk = ~ref_clk;
  task automatic stop_test();
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_err(logic got, logic exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: err flag %b", $time, got);
    end
  endtask
  task automatic chk_word(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: stored %h not %h", $time, got, exp);
    end
  endtask
  task automatic put(eepw_mode_t m, logic [14:0] a, logic [31:0] v, logic l);
    int t = 0;
    @(negedge ref_clk);
    while (req_ready !== 1'b1 && t < 8000) begin
      @(negedge ref_clk);
      t++;
    end
    if (t == 8000) begin
      n_errors++;
      $display("Error %0t: request never taken", $time);
    end
    req_valid = 1;
    req_mode = m;
    req_addr = a;
    req_data = v;
    req_last = l;
    @(negedge ref_clk);
    req_valid = 0;
  endtask
  task automatic idle();
    int t = 0;
    while (exp_q.size() > 0 && t < 9000) begin
      @(negedge ref_clk);
      t++;
    end
    if (exp_q.size() > 0) begin
      n_errors++;
      $display("Error %0t: no done pulse", $time);
    end
  endtask
  // done lasts one cycle, so every pulse is seen at exactly one low phase
  always @(negedge ref_clk) if (done === 1'b1) begin
    if (exp_q.size() == 0) chk_err(1'b1, 1'b0);
    else chk_err(err, exp_q.pop_front());
  end
  initial begin
    // about 17k cycles of tests; this leaves ample margin
    #120000;
    n_errors++;
    $display("Error %0t: watchdog expired", $time);
    stop_test();
  end
  initial begin
    req_valid = 1'b0;
    req_nodata = 1'b0;
    req_last = 1'b0;
    req_mode = MD_PLAIN;
    req_addr = 15'h0000;
    req_data = 32'h0;
    void'($urandom(3320));
    repeat (12) @(negedge ref_clk);
    rst = 0;
    // no last flag: the 64th byte has to close the page by itself
    for (int i = 0; i < 64; i++) begin
      d[i] = $urandom();
      put(MD_PLAIN, 15'h0040 + 15'(i), d[i], 1'b0);
    end
    exp_q.push_back(1'b0);
    idle();
    for (int i = 0; i < 64; i++)
      chk_word(i_mem.mem[15'h0040 + 15'(i)], d[i]);
    d[0] = $urandom();
    put(MD_PROTECT, 15'h0100, d[0], 1'b1);
    exp_q.push_back(1'b0);
    idle();
    chk_word(i_mem.mem[15'h0100], d[0]);
    put(MD_PLAIN, 15'h0100, ~d[0], 1'b1);
    exp_q.push_back(1'b1);
    idle();
    chk_word(i_mem.mem[15'h0100], d[0]);
    d[1] = $urandom();
    put(MD_UNPROTECT, 15'h0100, d[1], 1'b1);
    exp_q.push_back(1'b0);
    idle();
    chk_word(i_mem.mem[15'h0100], d[1]);
    d[2] = $urandom();
    put(MD_PLAIN, 15'h0101, d[2], 1'b1);
    exp_q.push_back(1'b0);
    idle();
    chk_word(i_mem.mem[15'h0101], d[2]);
    // bare command: protection switches at the end of its own write
    req_nodata = 1'b1;
    put(MD_PROTECT, 15'h0101, ~d[2], 1'b1);
    req_nodata = 1'b0;
    exp_q.push_back(1'b0);
    idle();
    put(MD_PLAIN, 15'h0101, ~d[2], 1'b1);
    exp_q.push_back(1'b1);
    idle();
    chk_word(i_mem.mem[15'h0101], d[2]);
    stop_test();
  end
endmodule // test_eeprom_page_write_protect
`default_nettype wire

// >>> src/eepw_host.sv
// page-write host: command prefixes, page loading, completion polling
`timescale 1ns/1ps
`default_nettype none
module eepw_host #(
  parameter int BLW_CYCLES = eepw_pkg::BLW_CYC,
  parameter int WC_CYCLES = eepw_pkg::WC_CYC,
  parameter int PWR_CYCLES = eepw_pkg::PWR_CYC,
  parameter logic [7:0] PROT_CODE = eepw_pkg::CODE_PROT_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire eepw_pkg::eepw_mode_t req_mode,
  input wire logic req_nodata,
  input wire logic req_last,
  input wire logic [eepw_pkg::ADDR_W-1:0] req_addr,
  input wire logic [eepw_pkg::DATA_W-1:0] req_data,
  output logic done,
  output logic err,
  output logic [eepw_pkg::ADDR_W-1:0] mem_addr,
  output logic [eepw_pkg::DATA_W-1:0] mem_dq_out,
  output logic mem_dq_oe_n,
  input wire logic [eepw_pkg::DATA_W-1:0] mem_dq_in,
  output logic mem_cs_n,
  output logic mem_we_n,
  output logic mem_oe_n
);
  import eepw_pkg::*;

  typedef enum logic [2:0] {
    M_BOOT, M_IDLE, M_SEQ, M_WRITE, M_LOAD, M_SETTLE, M_POLL
  } eepw_mst_t;

  typedef struct packed {
    eepw_mst_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] wc;
    eepw_mode_t mode;
    logic [2:0] idx;
    logic nodata;
    logic last;
    logic [ADDR_W-PAGE_LSB-1:0] page;
    logic [6:0] nbytes;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pdata;
    logic [ADDR_W-1:0] laddr;
    logic [DATA_W-1:0] ldata;
    logic creq;
    logic cwr;
    logic [ADDR_W-1:0] caddr;
    logic [DATA_W-1:0] cdata;
    logic ready;
    logic done;
    logic err;
  } eepw_host_t;

  eepw_host_t s_q, s_d;
  eepw_cyc_if cif ();

  function automatic logic [2:0] seq_len(input eepw_mode_t m);
    unique case (m)
      MD_PROTECT: seq_len = 3'd3; // RULE14 RULE15
      MD_UNPROTECT: seq_len = 3'd6; // RULE17
      default: seq_len = 3'd0;
    endcase
  endfunction

  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] i);
    seq_addr = (i == 3'd1 || i == 3'd4) ? SEQ_ADDR_B : SEQ_ADDR_A;
  endfunction

  function automatic logic [7:0] seq_code(input eepw_mode_t m,
                                          input logic [2:0] i);
    unique case (i)
      3'd0, 3'd3: seq_code = CODE_AA;
      3'd1, 3'd4: seq_code = CODE_55;
      3'd2: seq_code = (m == MD_UNPROTECT) ? CODE_80 : PROT_CODE;
      default: seq_code = CODE_20;
    endcase
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.cnt = s_q.cnt + 1'b1;
    unique case (s_q.st)
      M_BOOT: begin
        // let the device finish its own power-on write lockout
        if (s_q.cnt >= CNT_W'(PWR_CYCLES)) begin // RULE21
          s_d.st = M_IDLE;
          s_d.ready = 1'b1;
        end
      end
      M_IDLE: begin
        if (req_valid && s_q.ready) begin
          s_d.ready = 1'b0;
          s_d.err = 1'b0;
          s_d.mode = req_mode;
          s_d.nodata = req_nodata && (req_mode != MD_PLAIN);
          s_d.last = req_last;
          s_d.page = req_addr[ADDR_W-1:PAGE_LSB]; // RULE25
          s_d.paddr = req_addr;
          s_d.pdata = req_data;
          s_d.nbytes = '0;
          s_d.idx = '0;
          s_d.st = (req_mode == MD_PLAIN) ? M_WRITE : M_SEQ;
        end
      end
      M_SEQ: begin
        if (!s_q.creq && !cif.ack) begin
          // same code on every byte lane, one per chip
          s_d.creq = 1'b1;
          s_d.cwr = 1'b1;
          s_d.caddr = seq_addr(s_q.idx);
          s_d.cdata = {LANES{seq_code(s_q.mode, s_q.idx)}};
        end
        if (cif.ack) begin
          s_d.creq = 1'b0;
          s_d.laddr = s_q.caddr;
          s_d.ldata = s_q.cdata;
          s_d.idx = s_q.idx + 3'd1;
          s_d.cnt = '0;
          if (s_q.idx + 3'd1 == seq_len(s_q.mode)) begin
            // a bare sequence still waits out the window and programs
            s_d.st = s_q.nodata ? M_SETTLE : M_WRITE; // RULE20
          end
        end
      end
      M_WRITE: begin
        if (!s_q.creq && !cif.ack) begin
          s_d.creq = 1'b1;
          s_d.cwr = 1'b1;
          s_d.caddr = s_q.paddr;
          s_d.cdata = s_q.pdata;
        end
        if (cif.ack) begin
          s_d.creq = 1'b0;
          s_d.laddr = s_q.caddr;
          s_d.ldata = s_q.cdata;
          s_d.nbytes = s_q.nbytes + 7'd1;
          s_d.cnt = '0; // RULE7
          if (s_q.last || s_q.nbytes + 7'd1 == 7'(PAGE_BYTES)) begin // RULE6
            s_d.st = M_SETTLE;
          end else begin
            s_d.ready = 1'b1;
            s_d.st = M_LOAD;
          end
        end
      end
      M_LOAD: begin
        if (req_valid && s_q.ready) begin
          // only the low lines step; page bits stay locked
          s_d.paddr = {s_q.page, req_addr[PAGE_LSB-1:0]}; // RULE9 RULE25
          s_d.pdata = req_data;
          s_d.last = req_last;
          s_d.ready = 1'b0;
          s_d.st = M_WRITE;
        end else if (s_q.cnt >= CNT_W'(BLW_CYCLES - LOAD_MARGIN_CYC)) begin
          // close early: a byte started later might land past expiry
          s_d.ready = 1'b0; // RULE8
          s_d.st = M_SETTLE;
        end
      end
      M_SETTLE: begin
        // window must expire before the device starts programming
        if (s_q.cnt >= CNT_W'(BLW_CYCLES)) begin // RULE10
          s_d.wc = '0;
          s_d.st = M_POLL;
        end
      end
      M_POLL: begin
        // poll timeout is the same for one byte or a full page
        s_d.wc = s_q.wc + 1'b1; // RULE11
        if (!s_q.creq && !cif.ack) begin
          s_d.creq = 1'b1; // RULE5
          s_d.cwr = 1'b0;
          s_d.caddr = s_q.laddr;
        end
        if (cif.ack) begin
          s_d.creq = 1'b0;
          // whole word must match; a busy chip inverts its bit seven.
          // a bare command stores nothing: wait out the longest program
          if (!s_q.nodata && cif.rdata == s_q.ldata) begin // RULE3 RULE4
            s_d.done = 1'b1;
            s_d.ready = 1'b1;
            s_d.st = M_IDLE;
          end else if (s_q.wc >= CNT_W'(WC_CYCLES)) begin // RULE12
            s_d.err = !s_q.nodata;
            s_d.done = 1'b1;
            s_d.ready = 1'b1;
            s_d.st = M_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= M_BOOT;
      s_q.mode <= MD_PLAIN;
    end else begin
      s_q <= s_d;
    end
  end

  assign cif.req = s_q.creq;
  assign cif.wr = s_q.cwr;
  assign cif.addr = s_q.caddr;
  assign cif.wdata = s_q.cdata;
  assign req_ready = s_q.ready;
  assign done = s_q.done;
  assign err = s_q.err;

  eepw_pin_cycle u_pins (
    .ref_clk(ref_clk),
    .rst(rst),
    .cif(cif.cyc),
    .mem_addr(mem_addr),
    .mem_dq_out(mem_dq_out),
    .mem_dq_oe_n(mem_dq_oe_n),
    .mem_dq_in(mem_dq_in),
    .mem_cs_n(mem_cs_n),
    .mem_we_n(mem_we_n),
    .mem_oe_n(mem_oe_n)
  );
endmodule // eepw_host
`default_nettype wire

// >>> src/eepw_pin_cycle.sv
// pin driver: one timed write or read cycle on the eeprom pins
`timescale 1ns/1ps
`default_nettype none
module eepw_pin_cycle (
  input wire logic ref_clk,
  input wire logic rst,
  eepw_cyc_if.cyc cif,
  output logic [eepw_pkg::ADDR_W-1:0] mem_addr,
  output logic [eepw_pkg::DATA_W-1:0] mem_dq_out,
  output logic mem_dq_oe_n,
  input wire logic [eepw_pkg::DATA_W-1:0] mem_dq_in,
  output logic mem_cs_n,
  output logic mem_we_n,
  output logic mem_oe_n
);
  import eepw_pkg::*;

  typedef enum logic [2:0] {
    C_IDLE, C_SETUP, C_STROBE, C_RD, C_HOLD, C_GAP
  } eepw_cst_t;

  typedef struct packed {
    eepw_cst_t st;
    logic [7:0] cnt;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic dq_oe_n;
    logic cs_n;
    logic we_n;
    logic oe_n;
    logic [DATA_W-1:0] sync1;
    logic [DATA_W-1:0] sync2;
    logic [DATA_W-1:0] rdata;
    logic ack;
  } eepw_cyc_t;

  eepw_cyc_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.sync1 = mem_dq_in;
    s_d.sync2 = s_q.sync1;
    s_d.cnt = s_q.cnt + 8'h01;
    unique case (s_q.st)
      C_IDLE: begin
        s_d.cnt = '0;
        if (cif.req) begin
          s_d.wr = cif.wr;
          s_d.addr = cif.addr;
          s_d.dout = cif.wdata;
          if (cif.wr) begin
            // oe held high before strobes; a low oe inhibits the write
            s_d.oe_n = 1'b1; // RULE23
            s_d.dq_oe_n = 1'b0;
            s_d.st = C_SETUP;
          end else begin
            s_d.dq_oe_n = 1'b1; // RULE1
            s_d.cs_n = 1'b0;
            s_d.oe_n = 1'b0;
            s_d.st = C_RD;
          end
        end
      end
      C_SETUP: begin
        if (s_q.cnt == 8'(AS_CYC - 1)) begin
          // both strobes fall together so the address latch point is clean
          s_d.cs_n = 1'b0; // RULE2
          s_d.we_n = 1'b0;
          s_d.cnt = '0;
          s_d.st = C_STROBE;
        end
      end
      C_STROBE: begin
        // full-width pulse, far above the noise filter threshold
        if (s_q.cnt == 8'(WP_CYC - 1)) begin // RULE24
          s_d.cs_n = 1'b1;
          s_d.we_n = 1'b1;
          s_d.cnt = '0;
          s_d.st = C_HOLD;
        end
      end
      C_RD: begin
        // wait output-valid time plus the synchroniser depth
        if (s_q.cnt == 8'(OE_CYC + SYNC_CYC)) begin
          s_d.rdata = s_q.sync2;
          s_d.cs_n = 1'b1;
          s_d.oe_n = 1'b1;
          s_d.cnt = '0;
          s_d.st = C_HOLD;
        end
      end
      C_HOLD: begin
        // write: high-pulse width; read: let the device float its outputs
        if (s_q.cnt == 8'(s_q.wr ? WPH_CYC - 1 : DF_CYC - 1)) begin
          s_d.dq_oe_n = 1'b1;
          s_d.ack = 1'b1;
          s_d.st = C_GAP;
        end
      end
      C_GAP: s_d.st = C_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= C_IDLE;
      s_q.dq_oe_n <= 1'b1;
      s_q.cs_n <= 1'b1;
      s_q.we_n <= 1'b1;
      s_q.oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign cif.ack = s_q.ack;
  assign cif.rdata = s_q.rdata;
  assign mem_addr = s_q.addr;
  assign mem_dq_out = s_q.dout;
  assign mem_dq_oe_n = s_q.dq_oe_n;
  assign mem_cs_n = s_q.cs_n;
  assign mem_we_n = s_q.we_n;
  assign mem_oe_n = s_q.oe_n;
endmodule // eepw_pin_cycle
`default_nettype wire
